/* core/bus_flags_pkg.sv */
// Register map, field positions and reset values of the address-match and acknowledge flags.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package bus_flags_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [4:0] STATUS_OFS     = 5'h00;
	localparam logic [4:0] DATA_OFS       = 5'h04;
	localparam logic [4:0] CTRL_OFS       = 5'h08;
	localparam logic [4:0] OWN_ADDR_OFS   = 5'h0C;

	// ==========================================================
	// Field positions of bus_status_flags
	localparam int ACK_BIT_POS            = 0;
	localparam int GC_FLAG_POS            = 1;
	localparam int MATCH_FLAG_POS         = 2;

	// ==========================================================
	// Field positions of the control register
	localparam int CTRL_TRS_POS           = 0;
	localparam int CTRL_MASTER_POS        = 1;
	localparam int CTRL_FS_PRI_POS        = 2;
	localparam int CTRL_FS_SEC_POS        = 3;

	// ==========================================================
	// Reset values and constants
	localparam logic       FLAG_RESET     = 1'b0;
	localparam logic [3:0] CTRL_RESET     = 4'h0;
	localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
	localparam logic [7:0] GEN_CALL_BYTE  = 8'h00;
	localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
	localparam logic [3:0] ACK_SLOT_BIT   = 4'h8;

endpackage

/* core/link_events_if.sv */
// Events and decoded link state passed from the link engine to the flag core.
// Assumes both ends run on the same module clock.
`timescale 1ns/1ps
interface link_events_if;
	logic       start_p;
	logic       stop_p;
	logic       fall_p;
	logic       byte_done_p;
	logic       ack_rise_p;
	logic       active;
	logic       first;
	logic [3:0] bit_cnt;
	logic [7:0] rx_byte;
	logic       sda_s;

	modport engine (output start_p, stop_p, fall_p, byte_done_p, ack_rise_p, active, first,
		bit_cnt, rx_byte, sda_s);
	modport core   (input start_p, stop_p, fall_p, byte_done_p, ack_rise_p, active, first,
		bit_cnt, rx_byte, sda_s);
endinterface

/* core/link_engine.sv */
// Two-wire link sampler: synchronises the pins, finds start, stop and clock edges,
// counts bits of each frame and assembles received bytes.
// Assumes the pins are asynchronous to clk and much slower than it.
`timescale 1ns/1ps
module link_engine (
	input  wire logic    clk,
	input  wire logic    reset_n,
	input  wire logic    scl_pin,
	input  wire logic    sda_pin,
	link_events_if.engine ev
);
	// ==========================================================
	// Synchronisers; first stages feed only the second stages
	logic       scl_m_r, scl_s_r, scl_d_r;
	logic       sda_m_r, sda_s_r, sda_d_r;
	logic       active_r, first_r, byte_done_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic       rise, fall, start, stop;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= scl_pin;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= sda_pin;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	assign rise  = scl_s_r & ~scl_d_r;
	assign fall  = ~scl_s_r & scl_d_r;
	assign start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	assign stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// ==========================================================
	// Frame tracking
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			active_r    <= 1'b0;
			first_r     <= 1'b0;
			bit_cnt_r   <= 4'h0;
			shift_r     <= 8'h00;
			byte_done_r <= 1'b0;
		end else begin
			byte_done_r <= 1'b0;
			if (start) begin
				active_r  <= 1'b1;
				first_r   <= 1'b1;
				bit_cnt_r <= 4'h0;
			end else if (stop) begin
				active_r  <= 1'b0;
				first_r   <= 1'b0;
				bit_cnt_r <= 4'h0;
			end else if (rise && active_r) begin
				if (bit_cnt_r == bus_flags_pkg::ACK_SLOT_BIT) begin
					bit_cnt_r <= 4'h0;
					first_r   <= 1'b0;
				end else begin
					shift_r     <= {shift_r[6:0], sda_s_r};
					bit_cnt_r   <= bit_cnt_r + 4'h1;
					byte_done_r <= (bit_cnt_r == bus_flags_pkg::LAST_DATA_BIT);
				end
			end
		end
	end

	assign ev.start_p     = start;
	assign ev.stop_p      = stop;
	assign ev.fall_p      = fall;
	assign ev.byte_done_p = byte_done_r;
	assign ev.ack_rise_p  = rise & active_r & (bit_cnt_r == bus_flags_pkg::ACK_SLOT_BIT);
	assign ev.active      = active_r;
	assign ev.first       = first_r;
	assign ev.bit_cnt     = bit_cnt_r;
	assign ev.rx_byte     = shift_r;
	assign ev.sda_s       = sda_s_r;
endmodule // link_engine

/* core/bus_flags_core.sv */
// Slave-address match, general-call and acknowledge flags of a two-wire bus interface,
// with a classic Wishbone register port, a data register and acknowledge driving.
// Assumes scl and sda come from open-drain pins outside the clk domain.
//
// Operation
// - Slave receive, primary format 0: own or general-call first byte sets match flag.
// - Data register write in transmit or read in receive clears both flags.
// - Writing 0 to match flag after reading it as 1 clears it.
// - General-call byte in slave receive with either format select 0 sets flag.
// - Writing 0 to general-call flag after reading it as 1 clears it.
// - General-call flag carries meaning only in bus-format slave receive.
// - Transmit mode captures the receiver's acknowledge level in the ack slot.
// - Receive mode drives the programmed acknowledge bit in the ack slot once addressed or as master.
// - Acknowledge read returns captured value transmitting, programmed value receiving.
// - All three flags reset to 0 and are software readable and writable.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module bus_flags_core (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [4:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n
);
	// ==========================================================
	// Declarations
	link_events_if ev ();

	logic        ack_r;
	logic [31:0] rdata_r;
	logic        match_flag_r, gc_flag_r;
	logic        match_armed_r, gc_armed_r;
	logic        ack_rx_r, ack_sw_r;
	logic [3:0]  ctrl_r;
	logic [6:0]  own_addr_r;
	logic [7:0]  tx_data_r, rx_data_r;
	logic        drive_low_r, addr_acked_r;
	logic        req, wr_lo, rd_req;
	logic        trs, master, fs_pri, fs_sec, slave_rx;
	logic        own_hit, gc_hit, match_set, gc_set, data_access;
	logic        match_sw_clr, gc_sw_clr, ack_read_bit;

	link_engine u_link (
		.clk     (clk),
		.reset_n (reset_n),
		.scl_pin (scl_i),
		.sda_pin (sda_i),
		.ev      (ev.engine)
	);

	function automatic logic hit(input logic [4:0] adr, input logic [4:0] ofs);
		hit = (adr == ofs);
	endfunction

	// ==========================================================
	// Mode decode
	assign trs      = ctrl_r[bus_flags_pkg::CTRL_TRS_POS];
	assign master   = ctrl_r[bus_flags_pkg::CTRL_MASTER_POS];
	assign fs_pri   = ctrl_r[bus_flags_pkg::CTRL_FS_PRI_POS];
	assign fs_sec   = ctrl_r[bus_flags_pkg::CTRL_FS_SEC_POS];
	assign slave_rx = ~master & ~trs;

	// ==========================================================
	// Wishbone slave: one wait state, ack drops the cycle after it is given
	assign req    = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr_lo  = req & wb_we_i & wb_sel_i[0];
	assign rd_req = req & ~wb_we_i;

	always_ff @(posedge clk) begin
		if (!reset_n)
			ack_r <= 1'b0;
		else
			ack_r <= req;
	end

	assign ack_read_bit = trs ? ack_rx_r : ack_sw_r;

	// Unmapped offsets read zero and ignore writes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd_req) begin
			rdata_r <= 32'h0000_0000;
			if (hit(wb_adr_i, bus_flags_pkg::STATUS_OFS))
				rdata_r[2:0] <= {match_flag_r, gc_flag_r, ack_read_bit};
			else if (hit(wb_adr_i, bus_flags_pkg::DATA_OFS))
				rdata_r[7:0] <= rx_data_r;
			else if (hit(wb_adr_i, bus_flags_pkg::CTRL_OFS))
				rdata_r[3:0] <= ctrl_r;
			else if (hit(wb_adr_i, bus_flags_pkg::OWN_ADDR_OFS))
				rdata_r[6:0] <= own_addr_r;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdata_r;

	// ==========================================================
	// Control, own address and data registers
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl_r     <= bus_flags_pkg::CTRL_RESET;
			own_addr_r <= bus_flags_pkg::OWN_ADDR_RESET;
			tx_data_r  <= 8'h00;
		end else if (wr_lo) begin
			if (hit(wb_adr_i, bus_flags_pkg::CTRL_OFS))
				ctrl_r <= wb_dat_i[3:0];
			if (hit(wb_adr_i, bus_flags_pkg::OWN_ADDR_OFS))
				own_addr_r <= wb_dat_i[6:0];
			if (hit(wb_adr_i, bus_flags_pkg::DATA_OFS))
				tx_data_r <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			rx_data_r <= 8'h00;
		else if (ev.byte_done_p && !trs)
			rx_data_r <= ev.rx_byte;
	end

	// ==========================================================
	// Recognition events and clears
	assign own_hit   = ev.rx_byte[7:1] == own_addr_r;
	assign gc_hit    = ev.rx_byte == bus_flags_pkg::GEN_CALL_BYTE;
	assign match_set = ev.byte_done_p & ev.first & slave_rx & ~fs_pri
		& (own_hit | gc_hit);
	// Only set in slave receive; a flag set there keeps its value when the mode changes
	assign gc_set    = ev.byte_done_p & ev.first & slave_rx & (~fs_sec | ~fs_pri)
		& gc_hit;

	assign data_access = hit(wb_adr_i, bus_flags_pkg::DATA_OFS)
		& ((req & wb_we_i & trs) | (rd_req & ~trs));

	// Write of 0 to a flag bit; a write of 1 leaves the flag alone
	assign match_sw_clr = wr_lo & hit(wb_adr_i, bus_flags_pkg::STATUS_OFS)
		& ~wb_dat_i[bus_flags_pkg::MATCH_FLAG_POS] & match_armed_r;
	assign gc_sw_clr    = wr_lo & hit(wb_adr_i, bus_flags_pkg::STATUS_OFS)
		& ~wb_dat_i[bus_flags_pkg::GC_FLAG_POS] & gc_armed_r;

	// ==========================================================
	// Flags: set wins over any clear in the same cycle
	always_ff @(posedge clk) begin
		if (!reset_n)
			match_flag_r <= bus_flags_pkg::FLAG_RESET;
		else if (match_set)
			match_flag_r <= 1'b1;
		else if (data_access || match_sw_clr)
			match_flag_r <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			gc_flag_r <= bus_flags_pkg::FLAG_RESET;
		else if (gc_set)
			gc_flag_r <= 1'b1;
		else if (data_access || gc_sw_clr)
			gc_flag_r <= 1'b0;
	end

	// Arming: a read of 1 arms the clear, a newer set disarms it
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			match_armed_r <= 1'b0;
			gc_armed_r    <= 1'b0;
		end else begin
			if (match_set || data_access || match_sw_clr)
				match_armed_r <= 1'b0;
			else if (rd_req && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS) && match_flag_r)
				match_armed_r <= 1'b1;
			if (gc_set || data_access || gc_sw_clr)
				gc_armed_r <= 1'b0;
			else if (rd_req && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS) && gc_flag_r)
				gc_armed_r <= 1'b1;
		end
	end

	// ==========================================================
	// Acknowledge: two stores, selected by direction on read
	always_ff @(posedge clk) begin
		if (!reset_n)
			ack_sw_r <= bus_flags_pkg::FLAG_RESET;
		else if (wr_lo && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS))
			ack_sw_r <= wb_dat_i[bus_flags_pkg::ACK_BIT_POS];
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			ack_rx_r <= bus_flags_pkg::FLAG_RESET;
		else if (ev.ack_rise_p && trs)
			ack_rx_r <= ev.sda_s;
	end

	// ==========================================================
	// SDA drive, pulled low only on scl falling; start, stop and idle release it at once
	always_ff @(posedge clk) begin
		if (!reset_n)
			addr_acked_r <= 1'b0;
		else if (ev.start_p || ev.stop_p)
			addr_acked_r <= 1'b0;
		else if (match_set)
			addr_acked_r <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			drive_low_r <= 1'b0;
		end else if (ev.start_p || ev.stop_p || !ev.active) begin
			drive_low_r <= 1'b0;
		end else if (ev.fall_p) begin
			if (ev.bit_cnt == bus_flags_pkg::ACK_SLOT_BIT)
				drive_low_r <= ~trs & (addr_acked_r | master) & ~ack_sw_r;
			else if (trs && !ev.first)
				drive_low_r <= ~tx_data_r[3'(bus_flags_pkg::LAST_DATA_BIT - ev.bit_cnt)];
			else
				drive_low_r <= 1'b0;
		end
	end

	// Open-drain: output value fixed low, enable active low while driving
	assign sda_o    = 1'b0;
	assign sda_oe_n = ~drive_low_r;

	// ==========================================================
	// Assertions
	property p_match_set;
		@(posedge clk) disable iff (!reset_n)
		match_set |=> match_flag_r;
	endproperty
	a_match_set: assert property (p_match_set) else $error("match flag not set");

	property p_data_clear;
		@(posedge clk) disable iff (!reset_n)
		data_access && !match_set && !gc_set |=> !match_flag_r && !gc_flag_r;
	endproperty
	a_data_clear: assert property (p_data_clear) else $error("data access left a flag set");

	property p_match_sw_clear;
		@(posedge clk) disable iff (!reset_n)
		rd_req && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS) && match_flag_r && !match_set
		##[3:10] match_sw_clr && !match_set
		|=> !match_flag_r;
	endproperty
	a_match_sw_clear: assert property (p_match_sw_clear) else $error("match clear failed");

	property p_gc_set;
		@(posedge clk) disable iff (!reset_n)
		ev.byte_done_p && ev.first && slave_rx && (!fs_sec || !fs_pri) && gc_hit
		|=> gc_flag_r && match_flag_r == ($past(fs_pri) ? $past(match_flag_r) : 1'b1);
	endproperty
	a_gc_set: assert property (p_gc_set) else $error("general call flag not set");

	property p_gc_sw_clear;
		@(posedge clk) disable iff (!reset_n)
		gc_sw_clr && !gc_set |=> !gc_flag_r ##1 !gc_armed_r;
	endproperty
	a_gc_sw_clear: assert property (p_gc_sw_clear) else $error("general call clear failed");

	property p_gc_only_slave_rx;
		@(posedge clk) disable iff (!reset_n)
		$rose(gc_flag_r) |-> $past(slave_rx) && $past(ev.first);
	endproperty
	a_gc_only_slave_rx: assert property (p_gc_only_slave_rx) else $error("gc set outside mode");

	property p_ack_capture;
		@(posedge clk) disable iff (!reset_n)
		ev.ack_rise_p && trs |=> ack_rx_r == $past(ev.sda_s);
	endproperty
	a_ack_capture: assert property (p_ack_capture) else $error("ack not captured");

	property p_ack_drive;
		@(posedge clk) disable iff (!reset_n)
		ev.fall_p && ev.active && !ev.start_p && !ev.stop_p
		&& ev.bit_cnt == bus_flags_pkg::ACK_SLOT_BIT && !trs && addr_acked_r
		|=> sda_oe_n == $past(ack_sw_r);
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("ack slot drive wrong");

	property p_ack_read;
		@(posedge clk) disable iff (!reset_n)
		rd_req && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS)
		|=> wb_ack_o && wb_dat_o[0] == ($past(trs) ? $past(ack_rx_r) : $past(ack_sw_r));
	endproperty
	a_ack_read: assert property (p_ack_read) else $error("ack read source wrong");

	property p_reset_values;
		@(posedge clk)
		!reset_n |=> !match_flag_r && !gc_flag_r && !ack_rx_r && !ack_sw_r && !wb_ack_o;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("flags not reset");

	property p_write_one_keeps;
		@(posedge clk) disable iff (!reset_n)
		wr_lo && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS) && match_flag_r
		&& wb_dat_i[bus_flags_pkg::MATCH_FLAG_POS] |=> match_flag_r;
	endproperty
	a_write_one_keeps: assert property (p_write_one_keeps) else $error("write of 1 cleared");

	// Primary format 1 must leave the match flag where it was
	property p_match_fs_blocks;
		@(posedge clk) disable iff (!reset_n)
		ev.byte_done_p && fs_pri && !data_access && !match_sw_clr |=> $stable(match_flag_r);
	endproperty
	a_match_fs_blocks: assert property (p_match_fs_blocks) else $error("match set in format 1");

	property p_match_unread_keep;
		@(posedge clk) disable iff (!reset_n)
		wr_lo && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS) && match_flag_r && !match_armed_r
		|=> match_flag_r;
	endproperty
	a_match_unread_keep: assert property (p_match_unread_keep) else $error("match lost");

	property p_gc_unread_keep;
		@(posedge clk) disable iff (!reset_n)
		wr_lo && hit(wb_adr_i, bus_flags_pkg::STATUS_OFS) && gc_flag_r && !gc_armed_r
		|=> gc_flag_r;
	endproperty
	a_gc_unread_keep: assert property (p_gc_unread_keep) else $error("general call lost");

	property p_ack_rx_hold;
		@(posedge clk) disable iff (!reset_n)
		!(ev.ack_rise_p && trs) |=> $stable(ack_rx_r);
	endproperty
	a_ack_rx_hold: assert property (p_ack_rx_hold) else $error("ack capture moved");

	// Outside the ack slot a receiver never holds the line
	property p_ack_release;
		@(posedge clk) disable iff (!reset_n)
		ev.fall_p && ev.bit_cnt != bus_flags_pkg::ACK_SLOT_BIT && !trs |=> sda_oe_n;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("data line held");

	property p_idle_released;
		@(posedge clk) disable iff (!reset_n)
		!ev.active |=> sda_oe_n;
	endproperty
	a_idle_released: assert property (p_idle_released) else $error("line driven when idle");

	property p_ack_pulse;
		@(posedge clk) disable iff (!reset_n)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("bus ack too long");

endmodule // bus_flags_core

/* tb/two_wire_master_model.sv */
// Behavioural remote master on the two-wire link: start, byte with ack slot, stop.
// Assumes open-drain lines with pull-ups; the bench ANDs all enables.
`timescale 1ns/1ps
module two_wire_master_model (
	output logic     scl,
	output logic     sda_drv_n,
	input  wire logic sda
);
	// ==========================================================
	// Idle: both lines released, link clock stands still high
	initial begin
		scl = 1'b1;
		sda_drv_n = 1'b1;
	end

	// Odd offset keeps link edges away from the module clock edges
	task automatic start_cond();
		#7;
		sda_drv_n = 1'b0;
		#160;
		scl = 1'b0;
		#80;
	endtask

	task automatic xfer(input logic [7:0] b, input logic drv, input logic lvl,
		output logic seen);
		for (int i = 7; i >= 0; i--) begin
			sda_drv_n = b[i];
			#80;
			scl = 1'b1;
			#160;
			scl = 1'b0;
			#80;
		end
		sda_drv_n = drv ? lvl : 1'b1; // Receiver returns its ack level
		#80;
		scl = 1'b1;
		#80;
		seen = sda; // Transmitter samples the ack in the slot
		#80;
		scl = 1'b0;
		#80;
		// Data line is left to the stop that follows: one change per time step
	endtask

	task automatic stop_cond();
		sda_drv_n = 1'b0;
		#80;
		scl = 1'b1;
		#160;
		sda_drv_n = 1'b1;
		#160;
	endtask
endmodule // two_wire_master_model

/* tb/tb_top.sv */
// Self-checking bench for the match, general-call and acknowledge flags.
// Assumes the flag core and its package; reads are scored by a monitor queue.
`timescale 1ns/1ps
module tb_top;
	logic        clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [4:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, rnd;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, sda_oe_n, scl, sda_drv_n, sda, sda_o;
	integer      seed = 96708;
	int          err_count, check_count;
	logic [31:0] exp_q[$];
	logic [6:0]  own;
	logic        ack_seen;
	logic [7:0]  fs_tab [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
	logic [7:0]  st_tab [4] = '{8'h07, 8'h03, 8'h07, 8'h01};

	// Open drain with pull-up: low when any party enables its driver
	assign sda = sda_drv_n & sda_oe_n;
	always #20 clk = ~clk;

	bus_flags_core u_dut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
	two_wire_master_model u_master (.scl(scl), .sda_drv_n(sda_drv_n), .sda(sda));

	// ==========================================================
	// Checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Monitor takes the oldest note whenever read data is acknowledged
	always @(posedge clk) begin
		if (wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o === 1'b1) begin
			if (exp_q.size() > 0)
				check(wb_dat_o, exp_q.pop_front());
			else
				err_count++;
		end
	end

	// ==========================================================
	// Wishbone classic master; upper data bits are random noise
	task automatic wb_cycle(input logic we, input logic [4:0] adr, input logic [7:0] d);
		int n;
		rnd = $random(seed);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {rnd[31:8], d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			err_count++;
			final_report();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wb_read(input logic [4:0] adr, input logic [7:0] exp);
		exp_q.push_back({24'h00_0000, exp});
		wb_cycle(1'b0, adr, 8'h00);
	endtask

	task automatic frame(input logic [7:0] b, input logic drv, input logic lvl);
		u_master.start_cond();
		u_master.xfer(b, drv, lvl, ack_seen);
		u_master.stop_cond();
		@(posedge clk);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 5'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h00);
		wb_read(bus_flags_pkg::CTRL_OFS, 8'h00);
		wb_read(5'h10, 8'h00);
		own = $random(seed);
		if (own == 7'h00)
			own = 7'h5A;
		wb_write_own: wb_cycle(1'b1, bus_flags_pkg::OWN_ADDR_OFS, {1'b0, own});
		// Own address, programmed ack 0 pulls the line low
		frame({own, 1'b0}, 1'b0, 1'b0);
		check({31'h0000_0000, ack_seen}, 32'h0000_0000);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h04);
		wb_cycle(1'b1, bus_flags_pkg::STATUS_OFS, 8'h04);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h04);
		wb_cycle(1'b1, bus_flags_pkg::STATUS_OFS, 8'h00);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h00);
		// General call, programmed ack 1; a write of 0 without a read must not clear
		wb_cycle(1'b1, bus_flags_pkg::STATUS_OFS, 8'h01);
		frame(8'h00, 1'b0, 1'b0);
		check({31'h0000_0000, ack_seen}, 32'h0000_0001);
		wb_cycle(1'b1, bus_flags_pkg::STATUS_OFS, 8'h01);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h07);
		wb_read(bus_flags_pkg::DATA_OFS, 8'h00);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h01);
		// Every format select pairing, then clear by read of 1 and write of 0
		for (int i = 0; i < 4; i++) begin
			wb_cycle(1'b1, bus_flags_pkg::CTRL_OFS, fs_tab[i]);
			frame(8'h00, 1'b0, 1'b0);
			wb_read(bus_flags_pkg::STATUS_OFS, st_tab[i]);
			wb_cycle(1'b1, bus_flags_pkg::STATUS_OFS, 8'h01);
			wb_read(bus_flags_pkg::STATUS_OFS, 8'h01);
		end
		// Master mode carries no general-call information
		wb_cycle(1'b1, bus_flags_pkg::CTRL_OFS, 8'h02);
		frame(8'h00, 1'b0, 1'b0);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h01);
		// Transmit: data read keeps flags, data write clears them
		wb_cycle(1'b1, bus_flags_pkg::CTRL_OFS, 8'h00);
		frame({own, 1'b0}, 1'b0, 1'b0);
		wb_cycle(1'b1, bus_flags_pkg::CTRL_OFS, 8'h01);
		wb_read(bus_flags_pkg::DATA_OFS, {own, 1'b0});
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h04);
		// MSB 1: the first data bit leaves the line free, so the model's stop lands
		wb_cycle(1'b1, bus_flags_pkg::DATA_OFS, {1'b1, rnd[6:0]});
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h00);
		for (int l = 1; l >= 0; l--) begin
			frame(8'hFF, 1'b1, l[0]);
			wb_read(bus_flags_pkg::STATUS_OFS, {7'h00, l[0]});
		end
		// Back in receive the programmed value reads again
		wb_cycle(1'b1, bus_flags_pkg::CTRL_OFS, 8'h00);
		wb_read(bus_flags_pkg::STATUS_OFS, 8'h01);
		check({31'h0000_0000, sda_o}, 32'h0000_0000);
		if (exp_q.size() != 0)
			err_count++;
		final_report();
	end
endmodule // tb_top
